//--- core/dpr_pkg.sv
// shared constants and types of the dual-port ram ends and their host controller
// assumes a single pclk domain; both ends and the interface import this package
package dpr_pkg;

  // ==========================================================================
  // array geometry
  localparam int LANES  = 4;
  localparam int LANE_W = 9;
  localparam int DATA_W = LANES * LANE_W;
  localparam int ADDR_W = 15;                      // smallest density
  localparam int DEPTH  = 1 << ADDR_W;

  localparam logic [ADDR_W-1:0] MB_LEFT    = 15'h7ffe;
  localparam logic [ADDR_W-1:0] MB_RIGHT   = 15'h7fff;
  localparam logic [ADDR_W-1:0] CNT_RESET  = 15'h0000;
  localparam logic [ADDR_W-1:0] MASK_RESET = 15'h7fff;  // all ones: fully unmasked

  // ==========================================================================
  // host controller register map (byte addresses)
  localparam logic [7:0] OFF_CMD        = 8'h00;
  localparam logic [7:0] OFF_ADDR       = 8'h04;
  localparam logic [7:0] OFF_WDATA      = 8'h08;
  localparam logic [7:0] OFF_WDATA_HI   = 8'h0c;
  localparam logic [7:0] OFF_RDATA      = 8'h10;
  localparam logic [7:0] OFF_RDATA_HI   = 8'h14;
  localparam logic [7:0] OFF_STATUS     = 8'h18;
  localparam logic [7:0] OFF_INT_STATUS = 8'h1c;
  localparam logic [7:0] OFF_INT_MASK   = 8'h20;

  // command register fields
  localparam int CMD_READ    = 0;
  localparam int CMD_LOAD    = 1;
  localparam int CMD_ADVANCE = 2;
  localparam int CMD_CLEAR   = 3;
  localparam int CMD_MASKREG = 4;
  localparam int CMD_LANE_LO = 8;
  localparam int CMD_START   = 31;

  // status and interrupt bits
  localparam int ST_BUSY  = 0;
  localparam int INT_DONE = 0;
  localparam int INT_MB   = 1;
  localparam int INT_WRAP = 2;
  localparam int INT_W    = 3;

  typedef enum logic [2:0] {
    HS_IDLE  = 3'b001,
    HS_DRIVE = 3'b010,
    HS_CAPT  = 3'b100
  } dpr_hstate_t;

endpackage

//--- core/dpr_if.sv
// pins of one ram port, between the device end and one host end
// assumes both ends run on the same pclk; the data lines are resolved here
`timescale 1ns/1ns
interface dpr_if;
  import dpr_pkg::*;

  logic [ADDR_W-1:0] address_lines;
  logic              address_load_strobe_n;
  logic              chip_select_low_active_n;
  logic              chip_select_high_active;
  logic              counter_advance_n;
  logic              counter_clear_n;
  logic              mask_access_select;
  logic              rw_select;
  logic              output_drive_n;
  logic [LANES-1:0]  byte_lane_select_n;
  logic [DATA_W-1:0] host_data;
  logic              host_data_oe;
  logic [DATA_W-1:0] dev_data;
  logic [LANES-1:0]  dev_data_oe;
  logic              mailbox_flag_n;
  logic              counter_wrap_flag_n;
  logic [DATA_W-1:0] data_lines;

  // ==========================================================================
  // wire level: the host wins while it drives, undriven lanes read zero
  always_comb begin
    for (int l = 0; l < LANES; l++) begin
      if (host_data_oe)
        data_lines[l*LANE_W +: LANE_W] = host_data[l*LANE_W +: LANE_W];
      else if (dev_data_oe[l])
        data_lines[l*LANE_W +: LANE_W] = dev_data[l*LANE_W +: LANE_W];
      else
        data_lines[l*LANE_W +: LANE_W] = '0;
    end
  end

  modport device (
    input  address_lines, address_load_strobe_n, chip_select_low_active_n,
    input  chip_select_high_active, counter_advance_n, counter_clear_n,
    input  mask_access_select, rw_select, output_drive_n, byte_lane_select_n,
    input  data_lines,
    output dev_data, dev_data_oe, mailbox_flag_n, counter_wrap_flag_n
  );

  modport host (
    output address_lines, address_load_strobe_n, chip_select_low_active_n,
    output chip_select_high_active, counter_advance_n, counter_clear_n,
    output mask_access_select, rw_select, output_drive_n, byte_lane_select_n,
    output host_data, host_data_oe,
    input  data_lines, dev_data_oe, mailbox_flag_n, counter_wrap_flag_n
  );
endinterface

//--- core/dpr_port_ctrl.sv
// burst address counter, counter mask register and wrap flag of one port
// assumes its controls come from same-clock logic; reset is asynchronous
`timescale 1ns/1ns
module dpr_port_ctrl
  import dpr_pkg::*;
(
  input  wire logic              clk,          // port clock
  input  wire logic              rst_n,        // async reset, low
  input  wire logic [ADDR_W-1:0] addr,         // external address
  input  wire logic              load_n,       // load strobe, low
  input  wire logic              advance_n,    // advance, low
  input  wire logic              clear_n,      // clear, low
  input  wire logic              mask_sel,     // low selects mask register
  output logic      [ADDR_W-1:0] access_addr,  // address used this cycle
  output logic                   wrap_flag_n   // wrap flag, low
);

  typedef struct packed {
    logic [ADDR_W-1:0] cnt;
    logic [ADDR_W-1:0] mask;
    logic              wrap_n;
  } dpr_port_st_t;

  localparam dpr_port_st_t PORT_RESET = '{cnt: CNT_RESET, mask: MASK_RESET, wrap_n: 1'b1};

  dpr_port_st_t st_reg;
  dpr_port_st_t st_next;

  // masked bits are forced to one so the carry ripples straight across them
  function automatic logic [ADDR_W-1:0] bump(logic [ADDR_W-1:0] c, logic [ADDR_W-1:0] m);
    logic [ADDR_W-1:0] sum;
    sum  = (c | ~m) + 15'h0001;
    bump = (sum & m) | (c & ~m);
  endfunction

  // ==========================================================================
  // next state
  always_comb begin
    logic [ADDR_W-1:0] inc;
    inc     = bump(st_reg.cnt, st_reg.mask);
    st_next = st_reg;
    if (mask_sel) begin                                        // R8
      if (!clear_n) begin                                      // R6
        st_next.cnt    = st_reg.cnt & ~st_reg.mask;            // R5
        st_next.wrap_n = 1'b1;
      end else if (!load_n) begin
        st_next.cnt    = addr;                                 // R1
        st_next.wrap_n = 1'b1;
      end else if (!advance_n) begin                           // R4
        st_next.cnt = inc;                                     // R3
        if ((inc & st_reg.mask) == st_reg.mask)
          st_next.wrap_n = 1'b0;                               // R13
      end
    end else if (!load_n) begin
      st_next.mask = addr;                                     // R7
    end
    // while the mask register is selected no array access is made
    access_addr = st_next.cnt;
    wrap_flag_n = st_reg.wrap_n;
  end

  // ==========================================================================
  // state register
  always_ff @(posedge clk or negedge rst_n) begin              // R18
    if (!rst_n) begin
      st_reg <= PORT_RESET;                                    // R17
    end else begin
      st_reg <= st_next;
    end
  end

endmodule // dpr_port_ctrl

//--- core/dpr_device.sv
// device end: the dual-port array with its two port control blocks
// assumes each host is same-clock logic on pclk; master_init_n is asynchronous
//
// Operation
// [R1] load strobe low loads external address
// [R2] address width follows density, here 15
// [R3] advance low increments counter each clock
// [R4] load or clear suppresses the increment
// [R5] clear zeroes only unmasked counter bits
// [R6] clear wins over load and advance
// [R7] mask select low routes operations to mask; here only load reaches the mask, clear and advance are ignored
// [R8] mask select high runs normal counter operations
// [R9] data driven on reads only while enable low
// [R10] top two locations are the port mailboxes
// [R11] other port writing my mailbox lowers flag
// [R12] reading my own mailbox raises my flag
// [R13] wrap flag low when unmasked bits reach ones
// [R14] selected when low select low, high select high
// [R15] read/write low writes, high reads
// [R16] byte lane selects gate writes and drive
// [R17] master reset clears counters, masks, flags
// [R18] each port's logic runs on its own clock; here both ports run on the shared pclk
`timescale 1ns/1ns
module dpr_device
  import dpr_pkg::*;
(
  input  wire logic pclk,           // clock of both ports
  input  wire logic presetn,        // async reset, low
  input  wire logic master_init_n,  // async master reset, low
  dpr_if.device     left_port,      // port 0 pins
  dpr_if.device     right_port      // port 1 pins
);

  // ==========================================================================
  // state
  typedef struct packed {
    logic [1:0][DATA_W-1:0] rdata;
    logic [1:0][LANES-1:0]  drive;
    logic [1:0]             mb_n;
  } dpr_dev_st_t;

  localparam dpr_dev_st_t DEV_RESET = '{rdata: '0, drive: '0, mb_n: 2'b11};

  dpr_dev_st_t st_reg;
  dpr_dev_st_t st_next;

  logic [DATA_W-1:0] mem [DEPTH];

  logic                   rst_n;
  logic [1:0]             cs_n;
  logic [1:0]             cs_h;
  logic [1:0]             ld_n;
  logic [1:0]             adv_n;
  logic [1:0]             clr_n;
  logic [1:0]             msel;
  logic [1:0]             rw;
  logic [1:0]             oe_n;
  logic [1:0][LANES-1:0]  lane_n;
  logic [1:0][ADDR_W-1:0] ext_addr;
  logic [1:0][ADDR_W-1:0] acc;
  logic [1:0][DATA_W-1:0] din;
  logic [1:0]             wrap_n;
  logic [1:0]             rd;
  logic [1:0]             wr;

  function automatic logic [ADDR_W-1:0] mailbox_of(int p);
    mailbox_of = (p == 0) ? MB_LEFT : MB_RIGHT;                // R10
  endfunction

  // either reset alone returns every flop outside the array to its initial value
  assign rst_n = presetn & master_init_n;                      // R17

  // ==========================================================================
  // pins gathered into per-port arrays, index 0 left, 1 right
  assign ext_addr = {right_port.address_lines, left_port.address_lines}; // R2
  assign cs_n     = {right_port.chip_select_low_active_n, left_port.chip_select_low_active_n};
  assign cs_h     = {right_port.chip_select_high_active, left_port.chip_select_high_active};
  assign ld_n     = {right_port.address_load_strobe_n, left_port.address_load_strobe_n};
  assign adv_n    = {right_port.counter_advance_n, left_port.counter_advance_n};
  assign clr_n    = {right_port.counter_clear_n, left_port.counter_clear_n};
  assign msel     = {right_port.mask_access_select, left_port.mask_access_select};
  assign rw       = {right_port.rw_select, left_port.rw_select};
  assign oe_n     = {right_port.output_drive_n, left_port.output_drive_n};
  assign lane_n   = {right_port.byte_lane_select_n, left_port.byte_lane_select_n};
  assign din      = {right_port.data_lines, left_port.data_lines};

  // ==========================================================================
  // counter and mask of each port
  for (genvar p = 0; p < 2; p++) begin : g_port
    dpr_port_ctrl u_ctrl (
      .clk         (pclk),                                     // R18
      .rst_n       (rst_n),
      .addr        (ext_addr[p]),
      .load_n      (ld_n[p]),
      .advance_n   (adv_n[p]),
      .clear_n     (clr_n[p]),
      .mask_sel    (msel[p]),
      .access_addr (acc[p]),
      .wrap_flag_n (wrap_n[p])
    );
  end

  // ==========================================================================
  // access decode: an access needs the port selected, counter mode, one lane
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      logic hit;
      hit   = !cs_n[p] && cs_h[p] && msel[p] && (lane_n[p] != 4'hf);  // R14
      rd[p] = hit && rw[p];                                    // R15
      wr[p] = hit && !rw[p];                                   // R15
    end
  end

  // ==========================================================================
  // read pipeline and mailbox flags
  always_comb begin
    st_next = st_reg;
    for (int p = 0; p < 2; p++) begin
      if (rd[p]) begin
        st_next.rdata[p] = mem[acc[p]];
      end
      // enable is sampled with the read request since outputs are registered
      st_next.drive[p] = rd[p] ? (~lane_n[p] & {LANES{~oe_n[p]}}) : 4'h0;  // R9 R16
    end
    for (int p = 0; p < 2; p++) begin
      if (rd[p] && acc[p] == mailbox_of(p)) begin
        st_next.mb_n[p] = 1'b1;                                // R12
      end
      // a message arriving in the same cycle as the owner's read is kept
      if (wr[1-p] && acc[1-p] == mailbox_of(p)) begin
        st_next.mb_n[p] = 1'b0;                                // R11
      end
    end
  end

  always_ff @(posedge pclk or negedge rst_n) begin             // R18
    if (!rst_n) begin
      st_reg <= DEV_RESET;                                     // R17
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================================
  // array writes; the right port is last, so it wins a same-address collision
  always_ff @(posedge pclk) begin
    for (int p = 0; p < 2; p++) begin
      for (int l = 0; l < LANES; l++) begin
        if (wr[p] && !lane_n[p][l]) begin
          mem[acc[p]][l*LANE_W +: LANE_W] <= din[p][l*LANE_W +: LANE_W];  // R16
        end
      end
    end
  end

  // ==========================================================================
  // outputs, all from flops
  assign {right_port.dev_data, left_port.dev_data}             = st_reg.rdata;
  assign {right_port.dev_data_oe, left_port.dev_data_oe}       = st_reg.drive; // R9
  assign {right_port.mailbox_flag_n, left_port.mailbox_flag_n} = st_reg.mb_n;
  assign {right_port.counter_wrap_flag_n, left_port.counter_wrap_flag_n} = wrap_n; // R13

endmodule // dpr_device

//--- core/dpr_host.sv
// host end: runs one ram port cycle per software command, reached over apb
// assumes the device answers reads one cycle after the access cycle
`timescale 1ns/1ns
module dpr_host
  import dpr_pkg::*;
(
  input  wire logic        pclk,     // clock
  input  wire logic        presetn,  // async reset, low
  input  wire logic        psel,     // apb select
  input  wire logic        penable,  // apb enable
  input  wire logic        pwrite,   // apb direction
  input  wire logic [7:0]  paddr,    // apb byte address
  input  wire logic [31:0] pwdata,   // apb write data
  output logic      [31:0] prdata,   // apb read data
  output logic             pready,   // apb ready
  output logic             pslverr,  // apb error
  output logic             irq,      // level interrupt, high
  dpr_if.host              port      // ram port pins
);

  typedef struct packed {
    dpr_hstate_t       state;
    logic [31:0]       cmd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic [INT_W-1:0]  ist;
    logic [INT_W-1:0]  imask;
    logic              mb_q;
    logic              wrap_q;
    logic [ADDR_W-1:0] a;
    logic              ld_n, adv_n, clr_n, cs_n, cs_h, msel, rw, oe_n, dq_oe;
    logic [LANES-1:0]  lane_n;
    logic [31:0]       prdata;
    logic              pready, pslverr, irq;
  } dpr_host_st_t;

  localparam dpr_host_st_t HOST_RESET = '{state: HS_IDLE, mb_q: 1'b1, wrap_q: 1'b1,
    ld_n: 1'b1, adv_n: 1'b1, clr_n: 1'b1, cs_n: 1'b1, msel: 1'b1, rw: 1'b1,
    oe_n: 1'b1, lane_n: 4'hf, default: '0};

  dpr_host_st_t st_reg;
  dpr_host_st_t st_next;

  // ==========================================================================
  // next state
  always_comb begin
    logic [INT_W-1:0] ev;
    logic [INT_W-1:0] clr;
    logic             start;
    ev      = '0;
    clr     = '0;
    start   = 1'b0;
    st_next = st_reg;
    // pins idle unless a cycle is launched below
    {st_next.ld_n, st_next.adv_n, st_next.clr_n, st_next.cs_n, st_next.msel} = 5'h1f;
    {st_next.rw, st_next.oe_n, st_next.cs_h, st_next.dq_oe} = 4'hc;
    st_next.lane_n = 4'hf;
    st_next.pready  = psel && !penable;
    st_next.pslverr = 1'b0;
    if (psel && !penable) begin
      case (paddr)
        OFF_CMD:        st_next.prdata = st_reg.cmd;
        OFF_ADDR:       st_next.prdata = {17'h0_0000, st_reg.addr};
        OFF_WDATA:      st_next.prdata = st_reg.wdata[31:0];
        OFF_WDATA_HI:   st_next.prdata = {28'h000_0000, st_reg.wdata[DATA_W-1:32]};
        OFF_RDATA:      st_next.prdata = st_reg.rdata[31:0];
        OFF_RDATA_HI:   st_next.prdata = {28'h000_0000, st_reg.rdata[DATA_W-1:32]};
        OFF_STATUS:     st_next.prdata = {29'h0000_0000, !port.counter_wrap_flag_n,
                                          !port.mailbox_flag_n, st_reg.state != HS_IDLE};
        OFF_INT_STATUS: st_next.prdata = {29'h0000_0000, st_reg.ist};
        OFF_INT_MASK:   st_next.prdata = {29'h0000_0000, st_reg.imask};
        default: begin
          st_next.prdata  = 32'h0000_0000;
          st_next.pslverr = 1'b1;
        end
      endcase
    end
    if (psel && penable && st_reg.pready && pwrite) begin
      case (paddr)
        OFF_CMD: begin
          // a command written while a cycle runs is dropped
          if (st_reg.state == HS_IDLE) begin
            st_next.cmd = pwdata;
            start       = pwdata[CMD_START];
          end
        end
        OFF_ADDR:       st_next.addr = pwdata[ADDR_W-1:0];
        OFF_WDATA:      st_next.wdata[31:0] = pwdata;
        OFF_WDATA_HI:   st_next.wdata[DATA_W-1:32] = pwdata[3:0];
        OFF_INT_STATUS: clr = pwdata[INT_W-1:0];
        OFF_INT_MASK:   st_next.imask = pwdata[INT_W-1:0];
        default: ;
      endcase
    end
    case (st_reg.state)
      HS_IDLE: begin
        if (start) begin
          st_next.a      = st_reg.addr;
          st_next.cs_n   = 1'b0;                                        // R14
          st_next.cs_h   = 1'b1;                                        // R14
          st_next.ld_n   = !pwdata[CMD_LOAD];                           // R1
          st_next.adv_n  = !pwdata[CMD_ADVANCE];
          st_next.clr_n  = !pwdata[CMD_CLEAR];
          st_next.msel   = !pwdata[CMD_MASKREG];                        // R7
          st_next.rw     = pwdata[CMD_READ];                            // R15
          st_next.oe_n   = !pwdata[CMD_READ];                           // R9
          st_next.dq_oe  = !pwdata[CMD_READ];
          st_next.lane_n = ~pwdata[CMD_LANE_LO +: LANES];
          st_next.state  = HS_DRIVE;
        end
      end
      HS_DRIVE: begin
        if (st_reg.rw && st_reg.msel) begin
          st_next.state = HS_CAPT;
        end else begin
          st_next.state = HS_IDLE;
          ev[INT_DONE]  = 1'b1;
        end
      end
      HS_CAPT: begin
        st_next.rdata = port.data_lines;
        st_next.state = HS_IDLE;
        ev[INT_DONE]  = 1'b1;
      end
      default: st_next.state = HS_IDLE;
    endcase
    st_next.mb_q   = port.mailbox_flag_n;
    st_next.wrap_q = port.counter_wrap_flag_n;
    ev[INT_MB]     = st_reg.mb_q && !port.mailbox_flag_n;
    ev[INT_WRAP]   = st_reg.wrap_q && !port.counter_wrap_flag_n;
    // a new event wins over a write-one clear in the same cycle
    st_next.ist = (st_reg.ist & ~clr) | ev;
    st_next.irq = |(st_next.ist & st_next.imask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= HOST_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================================
  // outputs, all from flops
  assign prdata  = st_reg.prdata;
  assign pready  = st_reg.pready;
  assign pslverr = st_reg.pslverr;
  assign irq     = st_reg.irq;
  assign port.address_lines            = st_reg.a;
  assign port.address_load_strobe_n    = st_reg.ld_n;
  assign port.chip_select_low_active_n = st_reg.cs_n;
  assign port.chip_select_high_active  = st_reg.cs_h;
  assign port.counter_advance_n        = st_reg.adv_n;
  assign port.counter_clear_n          = st_reg.clr_n;
  assign port.mask_access_select       = st_reg.msel;
  assign port.rw_select                = st_reg.rw;
  assign port.output_drive_n           = st_reg.oe_n;
  assign port.byte_lane_select_n       = st_reg.lane_n;
  assign port.host_data                = st_reg.wdata;
  assign port.host_data_oe             = st_reg.dq_oe;

endmodule // dpr_host

//--- tb/dpr_port_props.sv
// checker: pin-level relations seen on the left ram port
// assumes one pclk domain; the bench instantiates it beside the left interface
`timescale 1ns/1ns
module dpr_port_props
  import dpr_pkg::*;
(
  input logic             pclk,                     // clock
  input logic             presetn,                  // reset, low
  input logic             chip_select_low_active_n, // select, low
  input logic             chip_select_high_active,  // select, high
  input logic             address_load_strobe_n,    // load
  input logic             counter_advance_n,        // advance
  input logic             counter_clear_n,          // clear
  input logic             mask_access_select,       // mode
  input logic             rw_select,                // direction
  input logic             output_drive_n,           // read drive
  input logic [LANES-1:0] byte_lane_select_n,       // lanes
  input logic [LANES-1:0] dev_data_oe,              // lane drive
  input logic             mailbox_flag_n,           // mailbox
  input logic             counter_wrap_flag_n       // wrap
);
  logic sel;
  logic idle;
  assign sel  = !chip_select_low_active_n && chip_select_high_active;
  assign idle = counter_advance_n && counter_clear_n && address_load_strobe_n;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================================
  // read drive
  AST_OE_SEL: assert property (dev_data_oe != 0 |-> $past(sel))
    else $error("lane drive without select");
  AST_OE_READ: assert property (dev_data_oe != 0 |-> $past(rw_select))
    else $error("lane drive after a write");
  AST_OE_ENABLE: assert property (dev_data_oe != 0 |-> $past(!output_drive_n))
    else $error("lane drive while drive enable high");
  AST_OE_LANES: assert property (dev_data_oe != 0 |-> dev_data_oe == ~$past(byte_lane_select_n))
    else $error("driven lanes differ from selected lanes");
  AST_OE_MODE: assert property (dev_data_oe != 0 |-> $past(mask_access_select))
    else $error("array read in mask mode");
  // ==========================================================================
  // counter wrap flag
  AST_WRAP_CLEAR: assert property (!counter_clear_n && mask_access_select |=> counter_wrap_flag_n)
    else $error("wrap flag low after clear");
  AST_WRAP_LOAD: assert property (!address_load_strobe_n && mask_access_select
    |=> counter_wrap_flag_n)
    else $error("wrap flag low after load");
  AST_WRAP_FALL: assert property ($fell(counter_wrap_flag_n) |-> $past(!counter_advance_n
    && counter_clear_n && address_load_strobe_n))
    else $error("wrap flag fell without a plain advance");
  AST_WRAP_HOLD: assert property (idle |=> $stable(counter_wrap_flag_n))
    else $error("wrap flag moved with no counter control");
  // ==========================================================================
  // mailbox flag; then covers of read drive, wrap flag and mailbox flag
  AST_MB_RISE: assert property ($rose(mailbox_flag_n)
    |-> $past(sel && rw_select && byte_lane_select_n != '1))
    else $error("mailbox flag rose without own read");
  AST_MB_HOLD: assert property (!mailbox_flag_n && !sel |=> !mailbox_flag_n)
    else $error("mailbox flag rose while port idle");
  COV_READ: cover property (dev_data_oe != 0);
  COV_WRAP: cover property ($fell(counter_wrap_flag_n));
  COV_MB: cover property ($fell(mailbox_flag_n));
endmodule // dpr_port_props

//--- tb/dual_port_ram_port_control_tb.sv
// bench: two apb hosts drive the two ports of one device end
// assumes the core package, interface and modules are compiled first
`timescale 1ns/1ns
module dual_port_ram_port_control_tb;
  import dpr_pkg::*;
  logic        pclk;
  logic        presetn;
  logic [1:0]  psel;
  logic [1:0]  penable;
  logic [1:0]  pwrite;
  logic [7:0]  paddr [2];
  logic [31:0] pwdata [2];
  logic [31:0] prdata [2];
  logic [1:0]  pready;
  logic [1:0]  pslverr;
  logic [1:0]  irq;
  logic [31:0] rv;
  logic [35:0] q;
  int          error_cnt;
  int          compares;
  dpr_if port_if [2] ();
  dpr_device dpr_device_inst (.pclk(pclk), .presetn(presetn), .master_init_n(presetn),
    .left_port(port_if[0]), .right_port(port_if[1]));
  for (genvar i = 0; i < 2; i++) begin : g_host
    dpr_host dpr_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel[i]),
      .penable(penable[i]), .pwrite(pwrite[i]), .paddr(paddr[i]), .pwdata(pwdata[i]),
      .prdata(prdata[i]), .pready(pready[i]), .pslverr(pslverr[i]), .irq(irq[i]),
      .port(port_if[i]));
  end
  dpr_port_props dpr_port_props_inst (.pclk, .presetn,
    .chip_select_low_active_n(port_if[0].chip_select_low_active_n),
    .chip_select_high_active(port_if[0].chip_select_high_active),
    .address_load_strobe_n(port_if[0].address_load_strobe_n),
    .counter_advance_n(port_if[0].counter_advance_n),
    .counter_clear_n(port_if[0].counter_clear_n),
    .mask_access_select(port_if[0].mask_access_select), .rw_select(port_if[0].rw_select),
    .output_drive_n(port_if[0].output_drive_n),
    .byte_lane_select_n(port_if[0].byte_lane_select_n), .dev_data_oe(port_if[0].dev_data_oe),
    .mailbox_flag_n(port_if[0].mailbox_flag_n),
    .counter_wrap_flag_n(port_if[0].counter_wrap_flag_n));
  always #25 pclk = ~pclk;
  // ==========================================================================
  // tasks
  task check(input logic [35:0] seen, input logic [35:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one edge first: a release and the next setup never share a step
  task apb(input int p, input logic w, input logic [7:0] a, input logic [31:0] d = '0);
    @(posedge pclk);
    psel[p]   <= 1'b1;
    pwrite[p] <= w;
    paddr[p]  <= a;
    pwdata[p] <= d;
    @(posedge pclk);
    penable[p] <= 1'b1;
    do @(posedge pclk); while (pready[p] !== 1'b1);
    rv = prdata[p];
    psel[p]    <= 1'b0;
    penable[p] <= 1'b0;
  endtask
  task run(input int p, input logic [4:0] op, input logic [3:0] ln, input logic [14:0] a,
           input logic [35:0] d = '0);
    apb(p, 1'b1, OFF_ADDR, {17'h0_0000, a});
    apb(p, 1'b1, OFF_WDATA, d[31:0]);
    apb(p, 1'b1, OFF_WDATA_HI, {28'h000_0000, d[35:32]});
    apb(p, 1'b1, OFF_CMD, {1'b1, 19'h0_0000, ln, 3'h0, op});
    rv = 32'h0000_0001;
    while (rv[ST_BUSY] !== 1'b0) apb(p, 1'b0, OFF_STATUS);
  endtask
  task rd(input int p);
    apb(p, 1'b0, OFF_RDATA);
    q[31:0] = rv;
    apb(p, 1'b0, OFF_RDATA_HI);
    q[35:32] = rv[3:0];
  endtask
  task wrap_up;
    $display("compares=%0d error_cnt=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ==========================================================================
  // tests; op bits: 1 read, 2 load, 4 advance, 8 clear, 16 mask register
  initial begin
    pclk = 1'b0; presetn = 1'b0; psel = '0; penable = '0; pwrite = '0;
    paddr  = '{default: '0};
    pwdata = '{default: '0};
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 1'b0, OFF_INT_MASK);
    check(port_if[0].mailbox_flag_n, 1);
    check(port_if[0].counter_wrap_flag_n, 1);
    $display("test reset done");
    run(0, 5'h02, 4'hf, 15'h0010, 36'h9_1234_5678);
    run(0, 5'h02, 4'hf, 15'h0011, 36'h1_aaaa_5555);
    run(0, 5'h02, 4'hf, 15'h0000, 36'h2_0bad_f00d);
    run(0, 5'h02, 4'h1, 15'h0010);
    run(0, 5'h03, 4'hf, 15'h0010);
    rd(0); check(q, 36'h9_1234_5600);
    run(0, 5'h03, 4'h2, 15'h0010);
    rd(0); check(q, 36'h0_0000_5600);
    run(0, 5'h05, 4'hf, 15'h0000);
    rd(0); check(q, 36'h1_aaaa_5555);
    run(0, 5'h0f, 4'hf, 15'h0010);
    rd(0); check(q, 36'h2_0bad_f00d);
    $display("test counter done");
    run(0, 5'h12, 4'h0, 15'h0003);
    run(0, 5'h02, 4'h0, 15'h0011);
    run(0, 5'h09, 4'hf, 15'h0000);
    rd(0); check(q, 36'h9_1234_5600);
    for (int i = 0; i < 3; i++) begin
      check(port_if[0].counter_wrap_flag_n, 1);
      run(0, 5'h04, 4'h0, 15'h0000);
    end
    check(port_if[0].counter_wrap_flag_n, 0);
    run(0, 5'h05, 4'hf, 15'h0000);
    rd(0); check(q, 36'h9_1234_5600);
    apb(0, 1'b0, OFF_INT_STATUS); check(rv[2:0], 3'h5);
    check(irq[0], 0);
    apb(0, 1'b1, OFF_INT_MASK, 32'h0000_0004);
    repeat (2) @(posedge pclk); check(irq[0], 1);
    apb(0, 1'b1, OFF_INT_STATUS, 32'h0000_0004);
    repeat (2) @(posedge pclk); check(irq[0], 0);
    run(0, 5'h12, 4'h0, 15'h7fff);
    $display("test mask done");
    run(1, 5'h02, 4'hf, MB_LEFT, 36'h5_0000_0001);
    check(port_if[0].mailbox_flag_n, 0);
    run(0, 5'h03, 4'h1, MB_LEFT);
    rd(0); check(q, 36'h0_0000_0001);
    check(port_if[0].mailbox_flag_n, 1);
    $display("test mailbox done");
    wrap_up;
  end
  // budget is generous: the tests need well under 2000 cycles
  initial begin
    #(50 * 20000);
    error_cnt++;
    wrap_up;
  end
endmodule // dual_port_ram_port_control_tb
